/* inc/pwm_steer_pkg.sv */
// Shared constants for the PWM output steering block
package pwm_steer_pkg;
   localparam int ADDR_W = 8;
   localparam int CNT_W  = 8;
   localparam int PINS   = 4;
   // Register byte offsets
   localparam logic [7:0] OFS_VALUE_LOW  = 8'h00;
   localparam logic [7:0] OFS_VALUE_HIGH = 8'h04;
   localparam logic [7:0] OFS_CCP_CTRL   = 8'h08;
   localparam logic [7:0] OFS_SHUT_CTRL  = 8'h0c;
   localparam logic [7:0] OFS_PWM_CTRL   = 8'h10;
   localparam logic [7:0] OFS_STEER      = 8'h14;
   localparam logic [7:0] OFS_PERIOD     = 8'h18;
   localparam logic [7:0] OFS_COUNT      = 8'h1c;
   localparam logic [7:0] OFS_POWER      = 8'h20;
   localparam logic [7:0] OFS_INT_STAT   = 8'h24;
   localparam logic [7:0] OFS_INT_MASK   = 8'h28;
   // Field positions
   localparam int CTL_P1M_HI  = 7;
   localparam int CTL_P1M_LO  = 6;
   localparam int CTL_MODE_HI = 3;
   localparam int CTL_MODE_LO = 2;
   localparam int CTL_POL_AC  = 1;
   localparam int CTL_POL_BD  = 0;
   localparam int SHUT_ASE    = 7;
   localparam int SHUT_AC_HI  = 3;
   localparam int SHUT_AC_LO  = 2;
   localparam int SHUT_BD_HI  = 1;
   localparam int SHUT_BD_LO  = 0;
   localparam int RESTART_EN  = 7;
   localparam int STEER_SYNC  = 4;
   localparam int PWR_FSCM    = 2;
   localparam int INT_OSC     = 0;
   localparam int INT_PERIOD  = 1;
   localparam int INT_SHUT    = 2;
   // Encodings and reset values
   localparam logic [1:0] P1M_SINGLE   = 2'h0;
   localparam logic [1:0] MODE_PWM     = 2'h3;
   localparam logic [4:0] STEER_RESET  = 5'h01;
   localparam logic [1:0] PM_RUN       = 2'h0;
   localparam logic [1:0] PM_PRIMARY_IDLE_MODE  = 2'h1;
   localparam logic [1:0] PM_ALT_CLOCK = 2'h2;
   localparam logic [1:0] PM_INT_OSC   = 2'h3;
endpackage

/* inc/steer_if.sv */
// Timebase link between clock select, timer and PWM core
`timescale 1ns/1ps
interface steer_if;
   import pwm_steer_pkg::*;
   logic             tick;
   logic [CNT_W-1:0] period;
   logic [CNT_W-1:0] count;
   logic             periodEnd;
   modport selector (output tick);
   modport timer    (input tick, input period, output count,
                     output periodEnd);
   modport core     (input count, input periodEnd, output period);
endinterface

/* hdl/clock_select.sv */
// Picks the timebase clock source per power mode
`timescale 1ns/1ps
module clock_select (
   input logic                    ref_clk,
   input logic                    rst,
   input logic                    sleepMode,
   input logic [1:0]              pmMode,
   input logic                    primaryTick,
   input logic                    altTick,
   input logic                    intOscTick,
   steer_if.selector              tb
);
   import pwm_steer_pkg::*;
   typedef struct packed { logic tick; } sel_state_t;
   sel_state_t s_reg, s_next;

   always_comb begin
      s_next = s_reg;
      if (sleepMode) begin
         s_next.tick = 1'b0;
      end else if (pmMode == PM_RUN || pmMode == PM_PRIMARY_IDLE_MODE) begin
         s_next.tick = primaryTick;
      end else if (pmMode == PM_INT_OSC) begin
         s_next.tick = intOscTick;
      end else begin
         s_next.tick = altTick;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) s_reg <= '0;
      else s_reg <= s_next;
   end
   assign tb.tick = s_reg.tick;

   primary_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
      !sleepMode && pmMode == PM_PRIMARY_IDLE_MODE |=> tb.tick == $past(primaryTick))
      else $error("idle mode lost primary clock");
   alt_clock_a: assert property (@(posedge ref_clk) disable iff (rst)
      !sleepMode && pmMode == PM_ALT_CLOCK |=> tb.tick == $past(altTick))
      else $error("timebase not on power-managed clock");
endmodule

/* hdl/pwm_timebase.sv */
// Period timer: counts ticks and restarts at the period value
`timescale 1ns/1ps
module pwm_timebase (
   input logic       ref_clk,
   input logic       rst,
   steer_if.timer    tb
);
   import pwm_steer_pkg::*;
   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic             periodEnd;
   } tb_state_t;
   tb_state_t s_reg, s_next;

   always_comb begin
      s_next = s_reg;
      s_next.periodEnd = 1'b0;
      // No tick means a frozen count, which is how sleep holds state
      if (tb.tick) begin
         if (s_reg.count == tb.period) begin
            s_next.count     = '0;
            s_next.periodEnd = 1'b1;
         end else begin
            s_next.count = s_reg.count + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) s_reg <= '0;
      else s_reg <= s_next;
   end
   assign tb.count     = s_reg.count;
   assign tb.periodEnd = s_reg.periodEnd;

   count_frozen_a: assert property (@(posedge ref_clk) disable iff (rst)
      !tb.tick |=> $stable(tb.count) && !tb.periodEnd)
      else $error("timebase moved without a tick");
endmodule

/* hdl/pwm_output_steering.sv */
// PWM unit with output steering, APB registers and interrupt
`timescale 1ns/1ps
// Overview of operation
// - Sync bit clear: new steering applies right after the register write.
// - Sync bit set: new steering waits for the next PWM period start.
// - Steering used only when output config is 00 and mode top bits 11.
// - In sleep the timebase stops and all unit state except the bus answer stays unchanged.
// - Sleep holds pin levels; wake-up resumes from the frozen state.
// - Primary-idle mode keeps the unit on the primary clock unchanged.
// - Other power modes clock the timebase from their selected clock.
// - Clock monitor failure: internal oscillator mode, fail flag, new clock.
// - Reset makes pins inputs and returns all registers to reset values.
// - Enabled pins carry PWM with chosen polarity; others are port pins.
// - Shutdown forces only PWM-enabled pins to their shutdown state.
module pwm_output_steering (
   input logic                              ref_clk,
   input logic                              rst,
   input logic                              psel,
   input logic                              penable,
   input logic                              pwrite,
   input logic [pwm_steer_pkg::ADDR_W-1:0]  paddr,
   input logic [31:0]                       pwdata,
   output logic [31:0]                      prdata,
   output logic                             pready,
   output logic                             pslverr,
   input logic                              sleepMode,
   input logic                              primaryTick,
   input logic                              altTick,
   input logic                              intOscTick,
   input logic                              primaryClkFail,
   input logic                              shutdownEvent,
   input logic [pwm_steer_pkg::PINS-1:0]    portOut,
   input logic [pwm_steer_pkg::PINS-1:0]    portOeN,
   output logic [pwm_steer_pkg::PINS-1:0]   pwmPinsOut,
   output logic [pwm_steer_pkg::PINS-1:0]   pwmPinsOeN,
   output logic                             irq
);
   import pwm_steer_pkg::*;

   typedef struct packed {
      logic [7:0]       valueLow;
      logic [7:0]       valueHigh;
      logic [7:0]       ccpCtrl;
      logic [7:0]       shutCtrl;
      logic [7:0]       pwmCtrl;
      logic [4:0]       steerCtrl;
      logic [PINS-1:0]  steerActive;
      logic             steerPending;
      logic [CNT_W-1:0] period;
      logic [1:0]       pmMode;
      logic             fscmEn;
      logic             oscFailed;
      logic             shutdownLatched;
      logic [2:0]       intStatus;
      logic [2:0]       intMask;
      logic [PINS-1:0]  pinOut;
      logic [PINS-1:0]  pinOeN;
      logic             irq;
      logic             pready;
      logic             pslverr;
      logic [31:0]      prdata;
   } core_state_t;

   core_state_t s_reg, s_next;
   steer_if     tbl ();

   logic wrStrobe;
   logic rdPhase;
   logic singleMode;
   logic pwmMode;
   logic pwmLevel;

   clock_select u_sel (
      .ref_clk     (ref_clk),
      .rst         (rst),
      .sleepMode   (sleepMode),
      .pmMode      (s_reg.pmMode),
      .primaryTick (primaryTick),
      .altTick     (altTick),
      .intOscTick  (intOscTick),
      .tb          (tbl.selector)
   );

   pwm_timebase u_tb (
      .ref_clk (ref_clk),
      .rst     (rst),
      .tb      (tbl.timer)
   );

   assign tbl.period = s_reg.period;

   // Read mux; unmapped offsets read zero and flag an error
   function automatic logic [32:0] readWord(input core_state_t st,
                                            input logic [CNT_W-1:0] cnt,
                                            input logic [ADDR_W-1:0] a);
      logic [32:0] r;
      r = '0;
      unique case (a)
         OFS_VALUE_LOW:  r[7:0] = st.valueLow;
         OFS_VALUE_HIGH: r[7:0] = st.valueHigh;
         OFS_CCP_CTRL:   r[7:0] = st.ccpCtrl;
         OFS_SHUT_CTRL:  r[7:0] = st.shutCtrl;
         OFS_PWM_CTRL:   r[7:0] = st.pwmCtrl;
         OFS_STEER:      r[4:0] = st.steerCtrl;
         OFS_PERIOD:     r[7:0] = st.period;
         OFS_COUNT:      r[7:0] = cnt;
         OFS_POWER:      r[3:0] = {st.oscFailed, st.fscmEn, st.pmMode};
         OFS_INT_STAT:   r[2:0] = st.intStatus;
         OFS_INT_MASK:   r[2:0] = st.intMask;
         default:        r[32]  = 1'b1;
      endcase
      return r;
   endfunction

   // Shutdown level for one pin: {output enable low, level}
   function automatic logic [1:0] shutDrive(input logic [1:0] sel);
      return sel[1] ? 2'b10 : {1'b0, sel[0]};
   endfunction

   // A and C share one polarity and shutdown pair, B and D the other
   function automatic logic isPairAc(input int pin);
      return pin % 2 == 0;
   endfunction

   assign wrStrobe   = psel && penable && s_reg.pready && pwrite;
   assign rdPhase    = psel && penable && !s_reg.pready;
   assign pwmMode    = s_reg.ccpCtrl[CTL_MODE_HI:CTL_MODE_LO] == MODE_PWM;
   assign singleMode = pwmMode &&
      s_reg.ccpCtrl[CTL_P1M_HI:CTL_P1M_LO] == P1M_SINGLE;
   assign pwmLevel   = tbl.count < s_reg.valueHigh;

   always_comb begin
      logic [32:0] rd;
      logic        pinOn;
      logic        inv;
      logic [1:0]  sd;
      rd    = readWord(s_reg, tbl.count, paddr);
      pinOn = 1'b0;
      inv   = 1'b0;
      sd    = '0;
      s_next = s_reg;
      // Bus answers one cycle into the access phase
      s_next.pready  = rdPhase;
      // Data and error stand only beside pready
      s_next.prdata  = '0;
      s_next.pslverr = 1'b0;
      if (rdPhase) begin
         s_next.prdata  = pwrite ? 32'h0 : rd[31:0];
         s_next.pslverr = rd[32];
      end
      // Sleep freezes all unit state except the bus answer, and pin levels; writes are dropped
      if (!sleepMode) begin
         if (tbl.periodEnd) begin
            s_next.valueHigh = s_reg.valueLow;
            if (s_reg.steerPending) begin
               s_next.steerActive  = s_reg.steerCtrl[PINS-1:0];
               s_next.steerPending = 1'b0;
            end
            // Restart only at a period boundary once the flag is clear
            if (!s_reg.shutCtrl[SHUT_ASE]) begin
               s_next.shutdownLatched = 1'b0;
            end
         end
         if (wrStrobe) begin
            unique case (paddr)
               OFS_VALUE_LOW:  s_next.valueLow  = pwdata[7:0];
               OFS_VALUE_HIGH: s_next.valueHigh = pwdata[7:0];
               OFS_CCP_CTRL:   s_next.ccpCtrl   = pwdata[7:0];
               OFS_SHUT_CTRL: begin
                  s_next.shutCtrl = pwdata[7:0];
                  // Clearing the flag is refused while the event persists
                  if (shutdownEvent) s_next.shutCtrl[SHUT_ASE] = 1'b1;
               end
               OFS_PWM_CTRL:   s_next.pwmCtrl   = pwdata[7:0];
               OFS_STEER: begin
                  s_next.steerCtrl = pwdata[4:0];
                  if (pwdata[STEER_SYNC]) begin
                     s_next.steerPending = 1'b1;
                  end else begin
                     s_next.steerActive  = pwdata[PINS-1:0];
                     s_next.steerPending = 1'b0;
                  end
               end
               OFS_PERIOD:     s_next.period    = pwdata[CNT_W-1:0];
               OFS_POWER: begin
                  s_next.fscmEn = pwdata[PWR_FSCM];
                  // A failed primary clock cannot be selected again
                  if (!s_reg.oscFailed) s_next.pmMode = pwdata[1:0];
               end
               OFS_INT_STAT:
                  s_next.intStatus = s_next.intStatus & ~pwdata[2:0];
               OFS_INT_MASK:   s_next.intMask   = pwdata[2:0];
               default: ;
            endcase
         end
         // Set wins over a clear written in the same cycle
         if (tbl.periodEnd) s_next.intStatus[INT_PERIOD] = 1'b1;
         if (shutdownEvent) begin
            if (!s_reg.shutCtrl[SHUT_ASE]) begin
               s_next.intStatus[INT_SHUT] = 1'b1;
            end
            s_next.shutCtrl[SHUT_ASE] = 1'b1;
         end else if (s_reg.pwmCtrl[RESTART_EN] && s_reg.shutCtrl[SHUT_ASE]) begin
            s_next.shutCtrl[SHUT_ASE] = 1'b0;
         end
         if (s_next.shutCtrl[SHUT_ASE]) s_next.shutdownLatched = 1'b1;
         if (s_reg.fscmEn && primaryClkFail && !s_reg.oscFailed) begin
            s_next.oscFailed = 1'b1;
            s_next.pmMode    = PM_INT_OSC;
            s_next.intStatus[INT_OSC] = 1'b1;
         end
         // Pin drive; pins without PWM fall back to the port latch
         for (int i = 0; i < PINS; i++) begin
            pinOn = singleMode ? s_reg.steerActive[i]
                               : (pwmMode && i == 0);
            inv = isPairAc(i) ? s_reg.ccpCtrl[CTL_POL_AC]
                              : s_reg.ccpCtrl[CTL_POL_BD];
            sd  = shutDrive(isPairAc(i)
                     ? s_reg.shutCtrl[SHUT_AC_HI:SHUT_AC_LO]
                     : s_reg.shutCtrl[SHUT_BD_HI:SHUT_BD_LO]);
            if (!pinOn) begin
               s_next.pinOut[i] = portOut[i];
               s_next.pinOeN[i] = portOeN[i];
            end else if (s_reg.shutdownLatched) begin
               s_next.pinOut[i] = sd[0];
               s_next.pinOeN[i] = sd[1];
            end else begin
               s_next.pinOut[i] = pwmLevel ^ inv;
               s_next.pinOeN[i] = 1'b0;
            end
         end
      end
      s_next.irq = |(s_next.intStatus & s_next.intMask);
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_reg             <= '0;
         s_reg.steerCtrl   <= STEER_RESET;
         s_reg.steerActive <= STEER_RESET[PINS-1:0];
         s_reg.pinOeN      <= '1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign prdata     = s_reg.prdata;
   assign pready     = s_reg.pready;
   assign pslverr    = s_reg.pslverr;
   assign pwmPinsOut = s_reg.pinOut;
   assign pwmPinsOeN = s_reg.pinOeN;
   assign irq        = s_reg.irq;

   sequence steerWrite(logic syncBit);
      wrStrobe && paddr == OFS_STEER && pwdata[STEER_SYNC] == syncBit
         && !sleepMode;
   endsequence
   sequence frozenSleep;
      sleepMode ##1 sleepMode;
   endsequence

   steer_now_a: assert property (@(posedge ref_clk) disable iff (rst)
      steerWrite(1'b0) |=> s_reg.steerActive == $past(pwdata[PINS-1:0]))
      else $error("immediate steering not applied");
   steer_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
      steerWrite(1'b1) and !tbl.periodEnd |=> $stable(s_reg.steerActive)
         && s_reg.steerPending)
      else $error("synchronised steering applied early");
   period_apply_a: assert property (@(posedge ref_clk) disable iff (rst)
      s_reg.steerPending && tbl.periodEnd && !sleepMode && !wrStrobe
         |=> s_reg.steerActive == $past(s_reg.steerCtrl[PINS-1:0])
             && s_reg.valueHigh == $past(s_reg.valueLow))
      else $error("period restart missed steering or duty reload");
   port_fallback_a: assert property (@(posedge ref_clk) disable iff (rst)
      !pwmMode && !sleepMode |=> pwmPinsOeN == $past(portOeN)
         && pwmPinsOut == $past(portOut))
      else $error("pins not released to port outside PWM mode");
   sleep_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
      frozenSleep |-> $stable(pwmPinsOut) && $stable(pwmPinsOeN)
         && $stable(s_reg.steerActive))
      else $error("pins or state changed in sleep");
   osc_fail_a: assert property (@(posedge ref_clk) disable iff (rst)
      s_reg.fscmEn && primaryClkFail && !s_reg.oscFailed && !sleepMode
         |=> s_reg.oscFailed && s_reg.intStatus[INT_OSC]
             && s_reg.pmMode == PM_INT_OSC ##1 tbl.tick == $past(intOscTick))
      else $error("clock failure not handled");
   reset_state_a: assert property (@(posedge ref_clk)
      rst |=> pwmPinsOeN == '1 && s_reg.steerCtrl == STEER_RESET
         && s_reg.ccpCtrl == 8'h00 && !irq)
      else $error("reset values wrong");
   shut_only_pwm_a: assert property (@(posedge ref_clk) disable iff (rst)
      singleMode && s_reg.shutdownLatched && !s_reg.steerActive[0]
         && !sleepMode |=> pwmPinsOut[0] == $past(portOut[0]))
      else $error("shutdown touched a port pin");
   polarity_a: assert property (@(posedge ref_clk) disable iff (rst)
      singleMode && s_reg.steerActive[0] && !s_reg.shutdownLatched
         && !sleepMode |=> pwmPinsOut[0] ==
             ($past(pwmLevel) ^ $past(s_reg.ccpCtrl[CTL_POL_AC]))
             && !pwmPinsOeN[0])
      else $error("steered pin polarity wrong");
   // Bus answer, interrupt and state guards
   answer_a: assert property (@(posedge ref_clk) disable iff (rst)
      psel && penable && !pready |=> pready)
      else $error("access phase not answered");
   answer_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
      pready |=> !pready && !pslverr && prdata == 32'h0)
      else $error("bus answer held too long");
   unmapped_a: assert property (@(posedge ref_clk) disable iff (rst)
      rdPhase && paddr > OFS_INT_MASK |=> pslverr && prdata == 32'h0)
      else $error("unmapped access not flagged");
   period_int_a: assert property (@(posedge ref_clk) disable iff (rst)
      tbl.periodEnd && !sleepMode |=> s_reg.intStatus[INT_PERIOD])
      else $error("period event lost");
   sleep_write_a: assert property (@(posedge ref_clk)
      disable iff (rst) sleepMode && wrStrobe |=> $stable(s_reg.steerCtrl)
         && $stable(s_reg.ccpCtrl) && $stable(s_reg.pmMode))
      else $error("register written during sleep");
   sleep_regs_a: assert property (@(posedge ref_clk)
      disable iff (rst) sleepMode |=> $stable(s_reg.valueHigh)
         && $stable(s_reg.intStatus))
      else $error("unit state changed in sleep");
   shut_set_a: assert property (@(posedge ref_clk)
      disable iff (rst) shutdownEvent && !sleepMode
         |=> s_reg.shutCtrl[SHUT_ASE] && s_reg.shutdownLatched)
      else $error("shutdown event not latched");
   shut_persist_a: assert property (@(posedge ref_clk)
      disable iff (rst) s_reg.shutdownLatched && !tbl.periodEnd
         |=> s_reg.shutdownLatched)
      else $error("shutdown ended before period start");
   fail_lock_a: assert property (@(posedge ref_clk)
      disable iff (rst) s_reg.oscFailed
         |=> s_reg.oscFailed && s_reg.pmMode == PM_INT_OSC)
      else $error("failed primary clock selected again");
   pin_release_a: assert property (@(posedge ref_clk)
      disable iff (rst) singleMode && !s_reg.steerActive[2] && !sleepMode
         |=> pwmPinsOeN[2] == $past(portOeN[2])
             && pwmPinsOut[2] == $past(portOut[2]))
      else $error("unsteered pin not on port");
   config_pin_a: assert property (@(posedge ref_clk)
      disable iff (rst) pwmMode && !singleMode && !s_reg.shutdownLatched
         && !sleepMode |=> !pwmPinsOeN[0]
             && pwmPinsOeN[3] == $past(portOeN[3]))
      else $error("other output config steered pins");
   steer_keep_a: assert property (@(posedge ref_clk)
      disable iff (rst) s_reg.steerPending && !tbl.periodEnd && !wrStrobe
         |=> $stable(s_reg.steerActive))
      else $error("pending steering applied early");
endmodule

/* test/pwm_load_model.sv */
// Load model: external switches on the four PWM pins, with pull-downs
`timescale 1ns/1ps
module pwm_load_model (
   input  wire logic [3:0] pinsOut,
   input  wire logic [3:0] pinsOeN,
   output logic      [3:0] pinLevel
);
   // Released pins fall to the pull-down, never keep the last level
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pinLevel[i] = pinsOeN[i] ? 1'b0 : pinsOut[i];
      end
   end
endmodule

/* test/pwm_output_steering_tb.sv */
// Register-level testbench for the PWM output steering block
`timescale 1ns/1ps
module pwm_output_steering_tb;
   import pwm_steer_pkg::*;
   logic              ref_clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata, rd, c0;
   logic              sleepMode, primaryTick, altTick, intOscTick;
   logic              primaryClkFail, shutdownEvent, irq, err;
   logic [PINS-1:0]   portOut, portOeN, pwmPinsOut, pwmPinsOeN, pinLevel;
   logic [PINS-1:0]   heldOut, heldOeN;
   int                miscompares, checked, hi;

   pwm_output_steering u_pwm_output_steering (.ref_clk(ref_clk), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sleepMode(sleepMode), .primaryTick(primaryTick), .altTick(altTick),
      .intOscTick(intOscTick), .primaryClkFail(primaryClkFail),
      .shutdownEvent(shutdownEvent), .portOut(portOut), .portOeN(portOeN),
      .pwmPinsOut(pwmPinsOut), .pwmPinsOeN(pwmPinsOeN), .irq(irq));
   pwm_load_model u_pwm_load_model (.pinsOut(pwmPinsOut),
      .pinsOeN(pwmPinsOeN), .pinLevel(pinLevel));

   initial ref_clk = 1'b0;
   always #2.5 ref_clk = ~ref_clk;

   task automatic close_out();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Holds the request until pready is seen at a rising edge, giving up after 20 edges
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      err = pslverr;
      if (k >= 20) check("pready", 0, 1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(what, rd, e);
   endtask

   task automatic count_high(input int pin);
      hi = 0;
      repeat (8) begin
         @(posedge ref_clk);
         hi += int'(pinLevel[pin]);
      end
   endtask

   task automatic wait_edges(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   initial begin
      #200000;
      miscompares++;
      close_out();
   end

   initial begin
      {rst, psel, penable, pwrite, paddr, pwdata} = '0;
      rst = 1'b1;
      {sleepMode, primaryClkFail, shutdownEvent} = 3'h0;
      {primaryTick, altTick, intOscTick} = 3'h7;
      portOut = 4'hd;
      portOeN = 4'h7;
      miscompares = 0;
      checked = 0;
      wait_edges(8);
      check("oe in reset", pwmPinsOeN, 4'hf);
      rst <= 1'b0;
      rdc("steer reset", OFS_STEER, 32'h01);
      rdc("ctrl reset", OFS_CCP_CTRL, 32'h00);
      rdc("unmapped", 8'h40, 32'h00);
      check("unmapped err", err, 1);
      $display("test reset done");
      wr(OFS_PERIOD, 32'h03);
      wr(OFS_VALUE_LOW, 32'h01);
      wr(OFS_VALUE_HIGH, 32'h01);
      wr(OFS_STEER, 32'h02);
      wr(OFS_CCP_CTRL, 32'h0d);
      wait_edges(2);
      check("pin a port", pwmPinsOeN[0], portOeN[0]);
      count_high(1);
      check("b active low", hi, 6);
      wr(OFS_CCP_CTRL, 32'h0c);
      wait_edges(2);
      count_high(1);
      check("b active high", hi, 2);
      wr(OFS_STEER, 32'h01);
      wait_edges(2);
      check("b cut at once", pwmPinsOeN[1], 1);
      check("a at once", pwmPinsOeN[0], 0);
      $display("test immediate steering done");
      wr(OFS_STEER, 32'h18);
      @(posedge ref_clk);
      check("a held", pwmPinsOeN[0], 0);
      hi = 0;
      while (pwmPinsOeN[0] !== 1'b1 && hi < 8) begin
         @(posedge ref_clk);
         hi++;
      end
      check("a released", pwmPinsOeN[0], 1);
      count_high(3);
      check("d whole periods", hi, 2);
      $display("test synced steering done");
      wr(OFS_CCP_CTRL, 32'h4c);
      wait_edges(2);
      check("other config a", pwmPinsOeN[0], 0);
      wr(OFS_CCP_CTRL, 32'h00);
      wait_edges(2);
      check("not pwm oe", pwmPinsOeN, portOeN);
      check("not pwm out", pwmPinsOut, portOut);
      wr(OFS_CCP_CTRL, 32'h0c);
      wr(OFS_STEER, 32'h00);
      wait_edges(2);
      check("none oe", pwmPinsOeN, portOeN);
      check("none out", pwmPinsOut, portOut);
      $display("test mode select done");
      wr(OFS_STEER, 32'h02);
      wr(OFS_SHUT_CTRL, 32'h01);
      wr(OFS_INT_MASK, 32'h00);
      shutdownEvent <= 1'b1;
      wait_edges(3);
      check("b shut oe", pwmPinsOeN[1], 0);
      check("b shut level", pwmPinsOut[1], 1);
      check("a untouched", pwmPinsOeN[0], portOeN[0]);
      check("a port level", pwmPinsOut[0], portOut[0]);
      apb(1'b0, OFS_INT_STAT, 32'h0);
      check("shut status", rd[INT_SHUT], 1);
      check("irq masked", irq, 0);
      wr(OFS_INT_MASK, 32'h04);
      wait_edges(2);
      check("irq raised", irq, 1);
      shutdownEvent <= 1'b0;
      wr(OFS_INT_STAT, 32'h04);
      wait_edges(2);
      check("irq cleared", irq, 0);
      wr(OFS_SHUT_CTRL, 32'h01);
      $display("test shutdown and interrupt done");
      sleepMode <= 1'b1;
      wait_edges(2);
      heldOut = pwmPinsOut;
      heldOeN = pwmPinsOeN;
      apb(1'b0, OFS_COUNT, 32'h0);
      c0 = rd;
      wait_edges(20);
      check("sleep out", pwmPinsOut, heldOut);
      check("sleep oe", pwmPinsOeN, heldOeN);
      rdc("sleep count", OFS_COUNT, c0);
      wr(OFS_STEER, 32'h08);
      rdc("sleep state", OFS_STEER, 32'h02);
      sleepMode <= 1'b0;
      wait_edges(2);
      apb(1'b0, OFS_COUNT, 32'h0);
      check("count resumes", rd !== c0, 1);
      $display("test sleep done");
      wr(OFS_POWER, 32'h02);
      altTick <= 1'b0;
      wait_edges(3);
      apb(1'b0, OFS_COUNT, 32'h0);
      c0 = rd;
      rdc("alt clock stopped", OFS_COUNT, c0);
      wr(OFS_POWER, 32'h01);
      apb(1'b0, OFS_COUNT, 32'h0);
      check("primary_idle_mode runs", rd !== c0, 1);
      $display("test power modes done");
      wr(OFS_POWER, 32'h04);
      primaryTick <= 1'b0;
      primaryClkFail <= 1'b1;
      wait_edges(4);
      rdc("fail mode", OFS_POWER, 32'h0f);
      wr(OFS_POWER, 32'h05);
      rdc("mode locked", OFS_POWER, 32'h0f);
      apb(1'b0, OFS_INT_STAT, 32'h0);
      check("fail flag", rd[INT_OSC], 1);
      apb(1'b0, OFS_COUNT, 32'h0);
      c0 = rd;
      wait_edges(1);
      apb(1'b0, OFS_COUNT, 32'h0);
      check("int osc clocks", rd !== c0, 1);
      $display("test clock failure done");
      rst <= 1'b1;
      wait_edges(8);
      check("oe second reset", pwmPinsOeN, 4'hf);
      rst <= 1'b0;
      rdc("steer again", OFS_STEER, 32'h01);
      rdc("power again", OFS_POWER, 32'h00);
      $display("test second reset done");
      close_out();
   end
endmodule
